// *** ssp_buf2.sv ***
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
module ssp_buf2 #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [1:0] count_q, count_d;
  logic push, pop;

  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb
  begin
    mem_d = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    if (push)
    begin
      mem_d[wrPtr_q] = inData;
      wrPtr_d = ~wrPtr_q;
    end
    if (pop)
      rdPtr_d = ~rdPtr_q;
    count_d = count_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end
    else
    begin
      mem_q <= mem_d;
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end
endmodule : ssp_buf2

// *** ssp_link_peer.sv ***
/*
  Link peer: a serial slave that returns a reply word MSB first and
  collects what the port sends. Assumes an SPI clock idling low.
*/
`timescale 1ns/100ps
module ssp_link_peer (
  input wire logic sClk,
  input wire logic frame,
  input wire logic mosi,
  output logic miso,
  input wire logic [15:0] reply,
  output logic [15:0] got,
  output int bits
);
  logic [15:0] sh = 16'h0000;
  initial
  begin
    miso = 1'b0;
    got = 16'h0000;
    bits = 0;
  end
  always @(posedge frame)
  begin
    sh = reply;
    miso = reply[15];
    got = 16'h0000;
    bits = 0;
  end
  always @(posedge sClk)
    if (frame)
    begin
      got = {got[14:0], mosi};
      bits++;
    end
  always @(negedge sClk)
    if (frame)
    begin
      sh = sh << 1;
      miso = sh[15];
    end
  // A released line shows the inverse, so a stale bit is never mistaken for data
  always @(negedge frame)
    miso = ~miso;
endmodule : ssp_link_peer

// *** ssp_pkg.sv ***
/*
  Types shared by the serial port control design.
  Assumes the constants header is compiled alongside.
*/
package ssp_pkg;
  typedef enum logic [1:0] {
    SSP_FMT_SPI = 2'h0,
    SSP_FMT_SYNC = 2'h1,
    SSP_FMT_CMD3 = 2'h2,
    SSP_FMT_RSVD = 2'h3
  } ssp_format_t;

  typedef enum logic [2:0] {
    SSP_IDLE = 3'b001,
    SSP_SHIFT = 3'b010,
    SSP_DONE = 3'b100
  } ssp_state_t;
endpackage : ssp_pkg

// *** ssp_port.sv ***
/*
  Synchronous serial port with its two control registers on APB.
  Master mode divides ref_clk into the serial clock; slave mode samples the
  external serial clock and frame pins through synchronisers.
  Assumes an APB master on ref_clk and a link clock well below ref_clk/4.
*/
// Register access over APB was decided locally.
`include "ssp_regs.svh"
`timescale 1ns/100ps
module ssp_port
  import ssp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic serialClockOut,
  output logic serialClockOe,
  input wire logic serialClockIn,
  output logic frameOut,
  output logic frameOe,
  input wire logic frameIn,
  output logic serialTxOut,
  output logic serialTxOe,
  input wire logic serialRxIn,
  output logic rxValid,
  input wire logic rxReady,
  output logic [15:0] rxData
);
  logic [15:0] ctrl0_q, ctrl0_d;
  logic [`SSP_C1_WIDTH-1:0] ctrl1_q, ctrl1_d;
  logic [7:0] presc_q, presc_d;
  logic [15:0] txWord_q, txWord_d;
  logic txFull_q, txFull_d;
  ssp_state_t state_q, state_d;
  logic [15:0] txShift_q, txShift_d;
  logic [15:0] rxShift_q, rxShift_d;
  logic [4:0] bitCnt_q, bitCnt_d;
  logic [15:0] divCnt_q, divCnt_d;
  logic sclk_q, sclk_d;
  logic frame_q, frame_d;
  logic sclkPrev_q, sclkPrev_d;
  logic [2:0] pinSync;
  logic sclkS, frameS, rxS;
  logic isMaster, isSlave;
  logic enabled, loopback, slave_output_disable;
  ssp_format_t fmt;
  logic [4:0] frameLen;
  logic halfTick, riseEdge, fallEdge, captureEdge, launchEdge;
  logic bitIn, busy;
  logic pushValid, pushReady;
  logic apbWrite, apbRead;
  logic dataRead;

  assign fmt = ssp_format_t'(ctrl0_q[`SSP_C0_FMT_MSB:`SSP_C0_FMT_LSB]);
  // Reserved sizes below four bits are not trapped; software must avoid them
  assign frameLen = {1'b0, ctrl0_q[`SSP_C0_SIZE_MSB:`SSP_C0_SIZE_LSB]} + 5'h01;
  assign slave_output_disable = ctrl1_q[`SSP_C1_SOD_BIT];
  assign isSlave = ctrl1_q[`SSP_C1_MS_BIT];
  assign isMaster = !isSlave;
  assign enabled = ctrl1_q[`SSP_C1_EN_BIT];
  assign loopback = ctrl1_q[`SSP_C1_LOOP_BIT];
  // Busy covers the wait for the trailing edge as well as the bits
  assign busy = (state_q != SSP_IDLE);

  // Pin inputs pass two flops before any logic reads them
  ssp_sync2 #(.WIDTH(3)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .asyncIn({serialClockIn, frameIn, serialRxIn}),
    .syncOut(pinSync)
  );
  assign {sclkS, frameS, rxS} = pinSync;

  // APB: zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && !pwrite;
  // Reading the data register in its access phase takes the word off the buffer
  assign dataRead = psel && penable && !pwrite && (paddr == `SSP_OFF_DATA);

  function automatic logic isMapped(input logic [11:0] addr);
    isMapped = (addr == `SSP_OFF_CTRL0) || (addr == `SSP_OFF_CTRL1) ||
      (addr == `SSP_OFF_DATA) || (addr == `SSP_OFF_STAT) || (addr == `SSP_OFF_PRESC);
  endfunction : isMapped

  assign pslverr = psel && penable && !isMapped(paddr);

  always_comb
  begin
    // Reserved and unused bits read as zero
    prdata = 32'h0000_0000;
    if (!apbRead)
      prdata = 32'h0000_0000;
    else if (paddr == `SSP_OFF_CTRL0)
      prdata = {16'h0000, ctrl0_q};
    else if (paddr == `SSP_OFF_CTRL1)
      prdata = {28'h000_0000, ctrl1_q};
    else if (paddr == `SSP_OFF_DATA)
      prdata = {16'h0000, rxData};
    else if (paddr == `SSP_OFF_STAT)
      prdata = {28'h000_0000, busy, rxValid, txFull_q, !txFull_q};
    else if (paddr == `SSP_OFF_PRESC)
      prdata = {24'h00_0000, presc_q};
  end

  always_comb
  begin
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    presc_d = presc_q;
    if (apbWrite && paddr == `SSP_OFF_CTRL0)
      ctrl0_d = pwdata[15:0];
    else if (apbWrite && paddr == `SSP_OFF_CTRL1)
      ctrl1_d = pwdata[`SSP_C1_WIDTH-1:0];
    else if (apbWrite && paddr == `SSP_OFF_PRESC)
      presc_d = pwdata[7:0];
  end

  // Master clock divider: half period = prescale*(1+rate)/2, at least one cycle
  always_comb
  begin
    logic [16:0] halfLen;
    halfLen = 17'({8'h00, presc_q} * ({8'h00, ctrl0_q[`SSP_C0_RATE_MSB:`SSP_C0_RATE_LSB]} +
      16'h0001)) >> 1;
    if (halfLen == 17'h0)
      halfLen = 17'h1;
    halfTick = (divCnt_q == 16'(halfLen - 17'h1));
  end

  // Edge roles: master uses its own toggles, slave uses the synchronised pin
  always_comb
  begin
    riseEdge = isMaster ? (halfTick && !sclk_q) : (sclkS && !sclkPrev_q);
    fallEdge = isMaster ? (halfTick && sclk_q) : (!sclkS && sclkPrev_q);
    // SPI with high idle captures on falling edges; other formats capture on rising
    if (fmt == SSP_FMT_SPI && ctrl0_q[`SSP_C0_POL_BIT])
    begin
      captureEdge = fallEdge;
      launchEdge = riseEdge;
    end
    else
    begin
      captureEdge = riseEdge;
      launchEdge = fallEdge;
    end
    bitIn = loopback ? txShift_q[15] : rxS;
  end

  // Frame sequencer: IDLE loads the shifter, SHIFT moves one bit per clock pair,
  // DONE hands the word on, a master only after waiting for the trailing edge
  always_comb
  begin
    state_d = state_q;
    txShift_d = txShift_q;
    rxShift_d = rxShift_q;
    bitCnt_d = bitCnt_q;
    // Divider runs only while a master frame is in progress
    divCnt_d = (busy && isMaster && !halfTick) ? divCnt_q + 16'h0001 : 16'h0000;
    sclk_d = sclk_q;
    frame_d = frame_q;
    sclkPrev_d = sclkS;
    txWord_d = txWord_q;
    txFull_d = txFull_q;
    pushValid = 1'b0;
    // A write while a word is still pending is dropped, not queued
    if (apbWrite && paddr == `SSP_OFF_DATA && !txFull_q)
    begin
      txWord_d = pwdata[15:0];
      txFull_d = 1'b1;
    end
    case (state_q)
      SSP_IDLE:
      begin
        sclk_d = (fmt == SSP_FMT_SPI) && ctrl0_q[`SSP_C0_POL_BIT];
        frame_d = 1'b0;
        if (enabled && txFull_q && (isMaster || frameS) && pushReady)
        begin
          txShift_d = txWord_q << (5'h10 - frameLen);
          txFull_d = 1'b0;
          // Cleared so that short words come out right-justified
          rxShift_d = 16'h0000;
          bitCnt_d = 5'h00;
          frame_d = 1'b1;
          state_d = SSP_SHIFT;
        end
      end
      SSP_SHIFT:
      begin
        if (isMaster && halfTick)
          sclk_d = !sclk_q;
        if (captureEdge)
        begin
          rxShift_d = {rxShift_q[14:0], bitIn};
          bitCnt_d = bitCnt_q + 5'h01;
        end
        if (launchEdge && bitCnt_q != 5'h00)
          txShift_d = {txShift_q[14:0], 1'b0};
        if (captureEdge && bitCnt_q + 5'h01 == frameLen)
          state_d = SSP_DONE;
        // Clearing enable mid-frame abandons the word
        if (!enabled)
          state_d = SSP_IDLE;
        // An SPI-format slave whose select drops early gives up the word instead of hanging
        if (isSlave && fmt == SSP_FMT_SPI && !frameS)
        begin
          frame_d = 1'b0;
          state_d = SSP_IDLE;
        end
      end
      SSP_DONE:
      begin
        // A slave hands its word on at once; a master waits for the trailing edge
        if (launchEdge || isSlave)
        begin
          pushValid = 1'b1;
          frame_d = 1'b0;
          state_d = SSP_IDLE;
        end
      end
      default:
        state_d = SSP_IDLE;
    endcase
  end

  // Registers only; every next value comes from the processes above
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl0_q <= 16'(`SSP_CTRL0_RESET);
      ctrl1_q <= `SSP_C1_WIDTH'(`SSP_CTRL1_RESET);
      presc_q <= 8'(`SSP_PRESC_RESET);
      txWord_q <= 16'h0000;
      txFull_q <= 1'b0;
      state_q <= SSP_IDLE;
      txShift_q <= 16'h0000;
      rxShift_q <= 16'h0000;
      bitCnt_q <= 5'h00;
      divCnt_q <= 16'h0000;
      sclk_q <= 1'b0;
      frame_q <= 1'b0;
      sclkPrev_q <= 1'b0;
    end
    else
    begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      presc_q <= presc_d;
      txWord_q <= txWord_d;
      txFull_q <= txFull_d;
      state_q <= state_d;
      txShift_q <= txShift_d;
      rxShift_q <= rxShift_d;
      bitCnt_q <= bitCnt_d;
      divCnt_q <= divCnt_d;
      sclk_q <= sclk_d;
      frame_q <= frame_d;
      sclkPrev_q <= sclkPrev_d;
    end
  end

  // Received words are right-justified by the left shift into rxShift
  ssp_buf2 #(.WIDTH(16)) u_rxbuf (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(rxShift_q),
    .outValid(rxValid),
    .outReady(rxReady || dataRead),
    .outData(rxData)
  );

  // Pin drivers: clock and frame are driven only by a master
  assign serialClockOut = sclk_q;
  assign serialClockOe = isMaster;
  assign frameOut = frame_q;
  assign frameOe = isMaster;
  assign serialTxOut = txShift_q[15];
  // Slaves sharing one line must release it; a slave in loopback keeps off it too
  assign serialTxOe = isMaster || !(slave_output_disable || loopback);
endmodule : ssp_port

// *** ssp_port_props.sv ***
/*
  Checker for the serial port: mirrors both control registers from APB
  writes and ties pin drive, idle clock and read data to them.
  Assumes it is bound to ssp_port and that pready answers every access.
*/
`timescale 1ns/100ps
module ssp_port_props
  import ssp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic serialClockOut,
  input wire logic serialClockOe,
  input wire logic frameOe,
  input wire logic serialTxOe
);
  logic [15:0] c0_q;
  logic [3:0] c1_q;
  logic [1:0] settle_q;
  logic wrCtl;
  logic quiet;
  assign wrCtl = psel & penable & pwrite & pready & (paddr[11:3] == 9'h000);
  // Pins may lag a write by a register stage, so look only once settled
  assign quiet = (settle_q == 2'h3);
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      c0_q <= 16'h0000;
      c1_q <= 4'h0;
      settle_q <= 2'h0;
    end
    else
    begin
      if (wrCtl && !paddr[2])
        c0_q <= pwdata[15:0];
      if (wrCtl && paddr[2])
        c1_q <= pwdata[3:0];
      settle_q <= wrCtl ? 2'h0 : (quiet ? settle_q : settle_q + 2'h1);
    end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  chk_idle_clk_pol:
    assert property (quiet && !c1_q[1] && c0_q[5:4] == 2'h0 |-> serialClockOut == c0_q[6])
    else $error("idle clock level wrong");
  chk_fmt_clk_low:
    assert property (quiet && !c1_q[1] && c0_q[5:4] != 2'h0 |-> !serialClockOut)
    else $error("idle clock follows polarity outside SPI");
  chk_sod_release:
    assert property (quiet && c1_q[2] && c1_q[3] |-> !serialTxOe)
    else $error("silenced slave drives transmit pin");
  chk_master_drive:
    assert property (quiet && !c1_q[2] && !c1_q[0] |-> serialTxOe && serialClockOe && frameOe)
    else $error("master does not drive its pins");
  chk_slave_drive:
    assert property (quiet && c1_q[2:0] == 3'h4 && !c1_q[3] |-> serialTxOe)
    else $error("slave does not drive transmit pin");
  chk_slave_pins_in:
    assert property (quiet && c1_q[2] |-> !serialClockOe && !frameOe)
    else $error("slave drives clock or frame");
  chk_loop_no_drive:
    assert property (quiet && c1_q[0] |-> serialTxOe == !c1_q[2])
    else $error("loopback transmit pin drive wrong");
  chk_ctrl1_read:
    assert property (psel && !pwrite && paddr == 12'h004 |-> prdata == {28'h0, c1_q})
    else $error("control one read wrong");
  chk_ctrl0_read:
    assert property (psel && !pwrite && paddr == 12'h000 |-> prdata[6:0] == c0_q[6:0])
    else $error("control zero read wrong");
endmodule : ssp_port_props

bind ssp_port ssp_port_props chk (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .serialClockOut(serialClockOut),
  .serialClockOe(serialClockOe),
  .frameOe(frameOe),
  .serialTxOe(serialTxOe)
);

// *** ssp_regs.svh ***
/*
  Register offsets, field positions, reset values and timing counts of the
  serial port control block. Assumes inclusion by bare name from the design.
*/
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

`define SSP_OFF_CTRL0 12'h000
`define SSP_OFF_CTRL1 12'h004
`define SSP_OFF_DATA 12'h008
`define SSP_OFF_STAT 12'h00C
`define SSP_OFF_PRESC 12'h010

`define SSP_CTRL0_RESET 32'h0000_0000
`define SSP_CTRL1_RESET 32'h0000_0000
`define SSP_PRESC_RESET 32'h0000_0000

`define SSP_C0_SIZE_LSB 0
`define SSP_C0_SIZE_MSB 3
`define SSP_C0_FMT_LSB 4
`define SSP_C0_FMT_MSB 5
`define SSP_C0_POL_BIT 6
`define SSP_C0_PHASE_BIT 7
`define SSP_C0_RATE_LSB 8
`define SSP_C0_RATE_MSB 15

`define SSP_C1_LOOP_BIT 0
`define SSP_C1_EN_BIT 1
`define SSP_C1_MS_BIT 2
`define SSP_C1_SOD_BIT 3
`define SSP_C1_WIDTH 4

`define SSP_SIZE_MIN 4'h3
`define SSP_CLK_PERIOD_NS 25
`define SSP_LINK_PERIOD_NS 200

`endif

// *** ssp_sync2.sv ***
/*
  Two flip-flop synchroniser for pin-level inputs.
  Assumes the input is asynchronous to ref_clk.
*/
`timescale 1ns/100ps
module ssp_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_q, stage2_q;

  assign syncOut = stage2_q;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1_q <= '0;
      stage2_q <= '0;
    end
    else
    begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end
endmodule : ssp_sync2

// *** sync_serial_port_control_tb.sv ***
/*
  Bench for the serial port: APB master tasks, a link peer and a queue
  model of received words. Assumes design and peer files compiled first.
*/
`timescale 1ns/100ps
module sync_serial_port_control_tb;
  import ssp_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic rxReady = 1'b0;
  logic err = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sClk, sClkOe, frm, frmOe, tx, txOe, rx, rxValid;
  logic [15:0] rxData, got;
  logic [15:0] rnd = 16'hC28D;
  logic [15:0] reply = 16'h0000;
  logic [15:0] expQ[$];
  int bits;
  int bad_count = 0;
  int samples_checked = 0;
  wire clkPin = sClkOe ? sClk : 1'b0;
  wire frmPin = frmOe ? frm : 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  ssp_port dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialClockOut(sClk), .serialClockOe(sClkOe),
    .serialClockIn(clkPin), .frameOut(frm), .frameOe(frmOe), .frameIn(frmPin),
    .serialTxOut(tx), .serialTxOe(txOe), .serialRxIn(rx), .rxValid(rxValid),
    .rxReady(rxReady), .rxData(rxData));
  ssp_link_peer peer (.sClk(clkPin), .frame(frmPin), .mosi(tx), .miso(rx), .reply(reply),
    .got(got), .bits(bits));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle cycle, so no strobe is dropped and raised in one time step
    @(posedge ref_clk);
  endtask : apb
  task automatic xfer(input logic [3:0] sz, input logic lb, input logic hold);
    logic [15:0] m;
    m = 16'hFFFF >> (15 - sz);
    rnd = lfsr(rnd);
    reply = lfsr(rnd) << (15 - sz);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, {28'h0, sz});
    apb(1'b1, 12'h008, {16'h0, rnd});
    apb(1'b1, 12'h004, {30'h0, 1'b1, lb});
    expQ.push_back(lb ? rnd & m : reply >> (15 - sz));
    if (hold)
    begin
      // Both buffer entries are taken, so the next frame must wait
      repeat (40) @(posedge ref_clk);
      check("frame start", 32'h0, frm);
      rxReady <= 1'b1;
    end
    rd = 32'hF;
    for (int n = 0; n < 300 && (rd[3] | rd[1]) !== 1'b0; n++)
      apb(1'b0, 12'h00C, 32'h0);
    check("port idle", 32'h0, {rd[3], rd[1]});
    if (!lb)
    begin
      check("peer bit count", sz + 1, bits);
      check("peer word", rnd & m, got);
    end
  endtask : xfer
  always @(posedge ref_clk)
    if (rxValid === 1'b1 && rxReady)
      check("rx word", expQ.size() ? expQ.pop_front() : 16'hXXXX, rxData);
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    give_verdict();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, 12'h004, 32'h0);
    check("ctrl1 reset", 32'h0, rd);
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl0 reset", 32'h0, rd);
    apb(1'b0, 12'h014, 32'h0);
    check("unmapped error", 32'h1, err);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      apb(1'b1, 12'h004, {28'h0, i[1:0], 1'b0, rnd[0]});
      apb(1'b0, 12'h004, 32'h0);
      check("ctrl1 read", {28'h0, i[1:0], 1'b0, rnd[0]}, rd);
      check("tx drive", !i[0] || !(rnd[0] || i[1]), txOe);
      check("clock drive", !i[0], sClkOe);
    end
    apb(1'b1, 12'h004, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, 12'h000, {25'h0, i[0], i[2:1], 4'h7});
      apb(1'b0, 12'h000, 32'h0);
      check("ctrl0 read", {25'h0, i[0], i[2:1], 4'h7}, rd);
      check("idle clock", i[0] & (i[2:1] == 2'h0), sClk);
    end
    apb(1'b1, 12'h010, 32'h8);
    xfer(4'h3, 1'b0, 1'b0);
    xfer(4'hF, 1'b0, 1'b0);
    xfer(4'h7, 1'b0, 1'b1);
    xfer(4'hB, 1'b1, 1'b0);
    repeat (20) @(posedge ref_clk);
    check("rx words left", 32'h0, expQ.size());
    give_verdict();
  end
endmodule : sync_serial_port_control_tb
